// file: frc_timer_core.sv
// Counter part, counter selection and four 20-bit capture channels
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Timer zero 20 bits, nibble plus high
// - High read latches nibble for later low read
// - Low nibble register: low bits ignored, read ones
// - Timer one 16-bit read-write up counter
// - Reset zeroes counters, low register 0FH, stopped
// - Each counter pulses interrupt on wraparound
// - Clock field divides timebase by power two
// - Control byte: clock fields and run bits
// - Control resets to 00H
// - Shared bus alternates timer values every clock
// - Eighteen modules each select timer zero/one
// - Module select accepts word writes only
// - Select extension reads ones in bits 7-2
// - Select registers reset to 0000H and FCH
// - Capture low nibble always from timer zero
// - Divided valid edges capture selected counter
// - Capture registers read-only, low bits read ones
// - Edge control word-only, bits 0-7 channels
// - Edge control resets 0000H, falling edges
// - Divide field codes 1/1 up to 1/64
// - Divide control layout, bits 3,7 read one
// - Divide controls reset to 88H
// - Capture: interrupt, snapshot divider, clear divider
// - Divider counts edges, matches ratio to capture
module frc_timer_core (
	// Clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           sys_rst,
	// Register port
	input  wire logic [8:0]                     reg_addr,
	input  wire logic [15:0]                    reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	input  wire logic                           reg_word,
	output logic      [15:0]                    reg_rdata,
	// Timebase and event pins
	input  wire logic                           timebase_clock,
	input  wire logic [frc_pkg::NUM_CAP-1:0]    capture_input,
	// Counter outputs to the register modules
	output logic      [15:0]                    shared_time_bus,
	output logic                                time_bus_is_t1,
	output logic      [3:0]                     timer0_nibble_out,
	output logic      [frc_pkg::NUM_MODULES-1:0] module_timer_sel,
	// Interrupt requests
	output logic                                timer0_ovf_irq,
	output logic                                timer1_ovf_irq,
	output logic      [frc_pkg::NUM_CAP-1:0]    capture_irq
);
	import frc_pkg::*;

	logic [7:0]  counter_control;
	logic [15:0] module_counter_select;
	logic [1:0]  module_counter_select_ext;
	logic [15:0] capture_edge_control;
	logic [7:0]  event_divide_ctrl_lo;
	logic [7:0]  event_divide_ctrl_hi;
	logic [3:0]  hold_nibble;
	logic [6:0]  tb_div;
	logic        bus_phase;
	logic [19:0] t0_val;
	logic [15:0] t1_val;
	logic [19:0] t0_load_val;
	logic        wr_t0_hi;
	logic        wr_t0_lo;
	logic        wr_t1;
	logic        t0_run;
	logic        t1_run;
	logic        t0_tick;
	logic        t1_tick;
	logic [15:0] next_rdata;
	logic [15:0] cap_hi [NUM_CAP];
	logic [3:0]  cap_nibble [NUM_CAP];
	logic [5:0]  edge_count [NUM_CAP];
	logic [5:0]  edge_snapshot [NUM_CAP];
	logic [2:0]  div_field [NUM_CAP];

	function automatic logic wr_at(input logic [8:0] a);
		return reg_wr && (reg_addr == a);
	endfunction

	function automatic logic rd_at(input logic [8:0] a);
		return reg_rd && (reg_addr == a);
	endfunction

	// A field of k passes every 2**k-th timebase tick
	function automatic logic prescale_tick(input logic [2:0] sel);
		logic [6:0] mask;
		mask = 7'((8'h01 << sel) - 8'h01);
		return timebase_clock && ((tb_div & mask) == mask);
	endfunction

	assign wr_t0_hi = wr_at(ADDR_T0_HI);
	assign wr_t0_lo = wr_at(ADDR_T0_LO);
	assign wr_t1    = wr_at(ADDR_T1);
	assign t0_run   = counter_control[CTRL_T0_RUN_BIT];
	assign t1_run   = counter_control[CTRL_T1_RUN_BIT];
	assign t0_tick  = t0_run
		&& prescale_tick(counter_control[CTRL_T0_CLK_LSB +: 3]);
	assign t1_tick  = t1_run
		&& prescale_tick(counter_control[CTRL_T1_CLK_LSB +: 3]);

	// Writes to either half keep the other half of timer zero
	assign t0_load_val = wr_t0_hi ? {reg_wdata, t0_val[3:0]}
		: {t0_val[19:4], reg_wdata[7:4]};

	assign timer0_nibble_out = t0_val[3:0];
	assign module_timer_sel  = {module_counter_select_ext,
		module_counter_select};

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_div <= 7'h00;
		end else if (timebase_clock) begin
			tb_div <= tb_div + 7'h01;
		end
	end

	frc_counter #(
		.WIDTH (20)
	) u_timer0 (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.count_en (t0_tick),
		.load     (wr_t0_hi || wr_t0_lo),
		.load_val (t0_load_val),
		.value    (t0_val),
		.overflow (timer0_ovf_irq)
	);

	frc_counter #(
		.WIDTH (16)
	) u_timer1 (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.count_en (t1_tick),
		.load     (wr_t1),
		.load_val (reg_wdata),
		.value    (t1_val),
		.overflow (timer1_ovf_irq)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			counter_control <= RST_CTRL;
		end else if (wr_at(ADDR_CTRL)) begin
			counter_control <= reg_wdata[7:0];
		end
	end

	// Byte writes would tear the selection, so they are dropped
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			module_counter_select <= RST_SEL;
		end else if (wr_at(ADDR_SEL) && reg_word) begin
			module_counter_select <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			module_counter_select_ext <= RST_SEL_EXT[1:0];
		end else if (wr_at(ADDR_SEL_EXT)) begin
			module_counter_select_ext <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			capture_edge_control <= RST_EDGE_CTRL;
		end else if (wr_at(ADDR_EDGE_CTRL) && reg_word) begin
			capture_edge_control <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			event_divide_ctrl_lo <= RST_EVDIV;
			event_divide_ctrl_hi <= RST_EVDIV;
		end else begin
			if (wr_at(ADDR_EVDIV_LO)) begin
				event_divide_ctrl_lo <= reg_wdata[7:0] | EVDIV_ONES;
			end
			if (wr_at(ADDR_EVDIV_HI)) begin
				event_divide_ctrl_hi <= reg_wdata[7:0] | EVDIV_ONES;
			end
		end
	end

	// Nibble frozen by a high-part read for a coherent 20-bit read
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_nibble <= RST_HOLD;
		end else if (rd_at(ADDR_T0_HI)) begin
			hold_nibble <= t0_val[3:0];
		end
	end

	// Bus shows the value of the timer named by time_bus_is_t1
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_phase       <= 1'b0;
			shared_time_bus <= RST_T1;
			time_bus_is_t1  <= 1'b1;
		end else begin
			bus_phase       <= !bus_phase;
			shared_time_bus <= bus_phase ? t1_val : t0_val[19:4];
			time_bus_is_t1  <= bus_phase;
		end
	end

	assign div_field[0] = event_divide_ctrl_lo[EVDIV_F0_LSB +: 3];
	assign div_field[1] = event_divide_ctrl_lo[EVDIV_F1_LSB +: 3];
	assign div_field[2] = event_divide_ctrl_hi[EVDIV_F0_LSB +: 3];
	assign div_field[3] = event_divide_ctrl_hi[EVDIV_F1_LSB +: 3];

	for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
		logic use_t1;
		assign use_t1 = module_counter_select[i];
		frc_capture_chan u_chan (
			.sys_clk       (sys_clk),
			.sys_rst       (sys_rst),
			.capture_input (capture_input[i]),
			.edge_sel      (capture_edge_control[2*i +: 2]),
			.div_field     (div_field[i]),
			.run           (use_t1 ? t1_run : t0_run),
			.counter_val   (use_t1 ? t1_val : t0_val[19:4]),
			.nibble        (t0_val[3:0]),
			.clr_count     (wr_at(ADDR_EDGE_CNT0 + 9'(i))),
			.snap_load     (wr_at(ADDR_EDGE_SNAP0 + 9'(i))),
			.snap_val      (reg_wdata[5:0]),
			.cap_hi        (cap_hi[i]),
			.cap_nibble    (cap_nibble[i]),
			.edge_count    (edge_count[i]),
			.edge_snapshot (edge_snapshot[i]),
			.capture_irq   (capture_irq[i])
		);
	end

	// Unmapped addresses read as zero
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr)
			ADDR_T0_HI:     next_rdata = t0_val[19:4];
			ADDR_T0_LO:     next_rdata = {8'h00, hold_nibble, LOW_ONES};
			ADDR_T1:        next_rdata = t1_val;
			ADDR_CTRL:      next_rdata = {8'h00, counter_control};
			ADDR_SEL:       next_rdata = module_counter_select;
			ADDR_SEL_EXT:   next_rdata = {8'h00, SEL_EXT_ONES,
				module_counter_select_ext};
			ADDR_EDGE_CTRL: next_rdata = capture_edge_control;
			ADDR_EVDIV_LO:  next_rdata = {8'h00, event_divide_ctrl_lo};
			ADDR_EVDIV_HI:  next_rdata = {8'h00, event_divide_ctrl_hi};
			default:        next_rdata = 16'h0000;
		endcase
		for (int i = 0; i < NUM_CAP; i++) begin
			if (reg_addr == ADDR_CAP_HI0 + 9'(i) * CAP_HI_STRIDE) begin
				next_rdata = cap_hi[i];
			end
			if (reg_addr == ADDR_CAP_LO0 + 9'(i)) begin
				next_rdata = {8'h00, cap_nibble[i], LOW_ONES};
			end
			if (reg_addr == ADDR_EDGE_CNT0 + 9'(i)) begin
				next_rdata = {8'h00, CNT_HIGH_ONES, edge_count[i]};
			end
			if (reg_addr == ADDR_EDGE_SNAP0 + 9'(i)) begin
				next_rdata = {8'h00, CNT_HIGH_ONES, edge_snapshot[i]};
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 16'h0000;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_bus_alternate: assert property (time_bus_is_t1 |=> !time_bus_is_t1
		##1 time_bus_is_t1)
		else $error("shared bus did not alternate");
	a_bus_value: assert property (##1 shared_time_bus ==
		(time_bus_is_t1 ? $past(t1_val) : $past(t0_val[19:4])))
		else $error("shared bus carries wrong timer");
	a_timer_overflow: assert property (timer1_ovf_irq |->
		t1_val == 16'h0000 && $past(t1_val) == 16'hFFFF)
		else $error("overflow pulse without wraparound");
	a_low_ones: assert property (rd_at(ADDR_T0_LO) |=>
		reg_rdata[3:0] == 4'hF)
		else $error("low nibble register low bits not ones");
	a_hold_coherent: assert property (rd_at(ADDR_T0_HI) ##1
		rd_at(ADDR_T0_LO) |=> reg_rdata[7:4] == $past(t0_val[3:0], 2))
		else $error("low read not coherent with high read");
	a_ext_ones: assert property (rd_at(ADDR_SEL_EXT) |=>
		reg_rdata[7:2] == 6'h3F)
		else $error("select extension upper bits not ones");
	a_word_only: assert property (wr_at(ADDR_SEL) && !reg_word |=>
		$stable(module_counter_select))
		else $error("byte write changed module select");
	a_stop_hold: assert property (!t1_run && !wr_t1 |=>
		$stable(t1_val) && !timer1_ovf_irq)
		else $error("stopped timer one moved");
	a_read_slot: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
	a_t0_overflow: assert property (timer0_ovf_irq |->
		t0_val == 20'h00000 && $past(t0_val) == 20'hFFFFF)
		else $error("timer zero overflow pulse without wraparound");
	a_t0_stop_hold: assert property (!t0_run && !wr_t0_hi
		&& !wr_t0_lo |=> $stable(t0_val) && !timer0_ovf_irq)
		else $error("stopped timer zero moved");
	a_t1_load: assert property (wr_t1 |=>
		t1_val == $past(reg_wdata))
		else $error("timer one write did not land");
	a_t0_high_load: assert property (wr_t0_hi |=>
		t0_val == {$past(reg_wdata), $past(t0_val[3:0])})
		else $error("timer zero high write did not land");
	a_edge_word_only: assert property (wr_at(ADDR_EDGE_CTRL)
		&& !reg_word |=> $stable(capture_edge_control))
		else $error("byte write changed edge control");
	a_evdiv_ones: assert property (rd_at(ADDR_EVDIV_LO)
		|| rd_at(ADDR_EVDIV_HI) |=> reg_rdata[7] && reg_rdata[3])
		else $error("missing divide control bits not ones");
	a_cap_low_ones: assert property (rd_at(ADDR_CAP_LO0) |=>
		reg_rdata[3:0] == LOW_ONES)
		else $error("capture low register low bits not ones");
	a_unmapped_zero: assert property (rd_at(9'h1FF) |=>
		reg_rdata == 16'h0000)
		else $error("unmapped address read not zero");

	c_t0_overflow: cover property (timer0_ovf_irq);
	c_coherent_read: cover property (rd_at(ADDR_T0_HI) ##1 rd_at(ADDR_T0_LO));
	c_t1_capture: cover property (module_counter_select[0] && capture_irq[0]);
	c_sel_word_write: cover property (wr_at(ADDR_SEL) && reg_word);
endmodule
`default_nettype wire

// file: frc_pkg.sv
// Shared constants for the free-running counters and capture channels
package frc_pkg;
	// Register byte addresses
	localparam logic [8:0]  ADDR_CAP_HI0    = 9'h08A;
	localparam logic [8:0]  ADDR_SEL        = 9'h0C2;
	localparam logic [8:0]  ADDR_SEL_EXT    = 9'h0C4;
	localparam logic [8:0]  ADDR_T0_LO      = 9'h0D3;
	localparam logic [8:0]  ADDR_T0_HI      = 9'h0D4;
	localparam logic [8:0]  ADDR_T1         = 9'h0D6;
	localparam logic [8:0]  ADDR_CAP_LO0    = 9'h0D8;
	localparam logic [8:0]  ADDR_CTRL       = 9'h0DC;
	localparam logic [8:0]  ADDR_EVDIV_LO   = 9'h0DE;
	localparam logic [8:0]  ADDR_EVDIV_HI   = 9'h0DF;
	localparam logic [8:0]  ADDR_EDGE_CNT0  = 9'h170;
	localparam logic [8:0]  ADDR_EDGE_SNAP0 = 9'h176;
	localparam logic [8:0]  ADDR_EDGE_CTRL  = 9'h17C;
	localparam logic [8:0]  CAP_HI_STRIDE   = 9'h002;

	// Values after reset
	localparam logic [19:0] RST_T0          = 20'h00000;
	localparam logic [15:0] RST_T1          = 16'h0000;
	localparam logic [7:0]  RST_CTRL        = 8'h00;
	localparam logic [15:0] RST_SEL         = 16'h0000;
	localparam logic [7:0]  RST_SEL_EXT     = 8'hFC;
	localparam logic [15:0] RST_EDGE_CTRL   = 16'h0000;
	localparam logic [7:0]  RST_EVDIV       = 8'h88;
	localparam logic [5:0]  RST_EDGE_CNT    = 6'h00;
	localparam logic [3:0]  RST_HOLD        = 4'h0;

	// Field positions and fixed bits
	localparam int          CTRL_T0_CLK_LSB = 0;
	localparam int          CTRL_T0_RUN_BIT = 3;
	localparam int          CTRL_T1_CLK_LSB = 4;
	localparam int          CTRL_T1_RUN_BIT = 7;
	localparam int          EVDIV_F0_LSB    = 0;
	localparam int          EVDIV_F1_LSB    = 4;
	localparam logic [7:0]  EVDIV_ONES      = 8'h88;
	localparam logic [3:0]  LOW_ONES        = 4'hF;
	localparam logic [5:0]  SEL_EXT_ONES    = 6'h3F;
	localparam logic [1:0]  CNT_HIGH_ONES   = 2'h3;

	// Edge select codes
	localparam logic [1:0]  EDGE_FALL       = 2'h0;
	localparam logic [1:0]  EDGE_RISE       = 2'h1;

	// Sizes
	localparam int          NUM_CAP         = 4;
	localparam int          NUM_MODULES     = 18;
	localparam logic [6:0]  DIV_MAX         = 7'h40;
endpackage

// file: frc_counter.sv
// Loadable up counter with one-cycle overflow pulse
`timescale 1ns/1ns
`default_nettype none
module frc_counter #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// Control
	input  wire logic             count_en,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	// State
	output logic      [WIDTH-1:0] value,
	output logic                  overflow
);
	// Software load wins over a count in the same cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			value <= '0;
		end else if (load) begin
			value <= load_val;
		end else if (count_en) begin
			value <= value + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			overflow <= 1'b0;
		end else begin
			overflow <= !load && count_en && (&value);
		end
	end
endmodule
`default_nettype wire

// file: frc_capture_chan.sv
// One capture channel: edge detect, event divider, capture latch
`timescale 1ns/1ns
`default_nettype none
module frc_capture_chan
	import frc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Event pin and setup
	input  wire logic        capture_input,
	input  wire logic [1:0]  edge_sel,
	input  wire logic [2:0]  div_field,
	input  wire logic        run,
	// Counter sources
	input  wire logic [15:0] counter_val,
	input  wire logic [3:0]  nibble,
	// Software access
	input  wire logic        clr_count,
	input  wire logic        snap_load,
	input  wire logic [5:0]  snap_val,
	// State
	output logic      [15:0] cap_hi,
	output logic      [3:0]  cap_nibble,
	output logic      [5:0]  edge_count,
	output logic      [5:0]  edge_snapshot,
	output logic             capture_irq
);
	logic       pin_prev;
	logic       valid;
	logic [6:0] count_inc;
	logic [6:0] div_val;
	logic       hit;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= capture_input;
		end
	end

	// No lockout: edges on successive clocks are each detected
	always_comb begin
		case (edge_sel)
			EDGE_FALL: valid = pin_prev && !capture_input;
			EDGE_RISE: valid = !pin_prev && capture_input;
			default:   valid = pin_prev ^ capture_input;
		endcase
	end

	assign div_val   = (div_field[2:1] == 2'h3) ? DIV_MAX
		: (7'h01 << div_field);
	assign count_inc = {1'b0, edge_count} + 7'h01;
	// Reaching the ratio also covers a ratio lowered mid-count
	assign hit = run && valid && (count_inc >= div_val);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			edge_count <= RST_EDGE_CNT;
		end else if (hit || clr_count) begin
			edge_count <= RST_EDGE_CNT;
		end else if (run && valid) begin
			edge_count <= count_inc[5:0];
		end
	end

	// Capture wins over a software write in the same cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			edge_snapshot <= RST_EDGE_CNT;
		end else if (hit) begin
			edge_snapshot <= count_inc[5:0];
		end else if (snap_load) begin
			edge_snapshot <= snap_val;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			capture_irq <= 1'b0;
		end else begin
			capture_irq <= hit;
		end
	end

	// Left without reset: contents undefined until the first capture
	always_ff @(posedge sys_clk) begin
		if (hit) begin
			cap_hi     <= counter_val;
			cap_nibble <= nibble;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_capture_clear: assert property (hit |=> edge_count == 6'h00
		&& capture_irq && edge_snapshot == $past(count_inc[5:0]))
		else $error("capture did not clear and snapshot divider");
	a_capture_load: assert property (hit |=> cap_hi == $past(counter_val)
		&& cap_nibble == $past(nibble))
		else $error("capture register not loaded");
	a_divider_stopped: assert property (!run && !clr_count
		|=> $stable(edge_count) && !capture_irq)
		else $error("divider moved while counter stopped");
	c_capture_hit: cover property (hit ##1 capture_irq);
endmodule
`default_nettype wire

// file: frc_event_src.sv
// Event source model driving the four capture pins
`timescale 1ns/1ns
`default_nettype none
module frc_event_src #(
	parameter int GAP = 3
) (
	// Clock
	input  wire logic       sys_clk,
	// Pulse train request
	input  wire logic       start,
	input  wire logic [1:0] chan,
	input  wire logic [7:0] pulses,
	// Pins and status
	output logic      [3:0] capture_input,
	output logic            busy
);
	// Pins idle high, as if pulled up; one process drives them
	initial begin
		capture_input = 4'hF;
		busy = 1'b0;
		// Each level held GAP clocks so every edge counts
		forever begin
			@(posedge sys_clk);
			if (start) begin
				busy <= 1'b1;
				repeat (pulses) begin
					capture_input[chan] <= 1'b0;
					repeat (GAP) @(posedge sys_clk);
					capture_input[chan] <= 1'b1;
					repeat (GAP) @(posedge sys_clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the counter and capture block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import frc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [8:0]  reg_addr = 9'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        reg_word = 1'b0;
	logic [15:0] reg_rdata;
	logic        timebase_clock = 1'b0;
	logic [3:0]  capture_input;
	logic [15:0] shared_time_bus;
	logic        time_bus_is_t1;
	logic [3:0]  timer0_nibble_out;
	logic [17:0] module_timer_sel;
	logic        timer0_ovf_irq;
	logic        timer1_ovf_irq;
	logic [3:0]  capture_irq;
	logic        start = 1'b0;
	logic [1:0]  chan = 2'h0;
	logic [7:0]  pulses = 8'h00;
	logic        busy;
	logic        ph;
	int          bad_count = 0;
	int          comparisons = 0;
	int          irq_cnt [4];
	int          r, e, c;
	logic [8:0]  ra [12] = '{ADDR_T0_HI, ADDR_T0_LO, ADDR_T1, ADDR_CTRL,
		ADDR_SEL, ADDR_SEL_EXT, ADDR_EDGE_CTRL, ADDR_EVDIV_LO, ADDR_EVDIV_HI,
		ADDR_EDGE_CNT0, ADDR_EDGE_SNAP0, 9'h1FF};
	logic [15:0] re [12] = '{16'h0000, 16'h000F, 16'h0000, 16'h0000,
		16'h0000, 16'h00FC, 16'h0000, 16'h0088, 16'h0088, 16'h00C0,
		16'h00C0, 16'h0000};

	frc_timer_core uut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_word, .reg_rdata, .timebase_clock, .capture_input,
		.shared_time_bus, .time_bus_is_t1, .timer0_nibble_out,
		.module_timer_sel, .timer0_ovf_irq, .timer1_ovf_irq, .capture_irq);
	frc_event_src src (.sys_clk, .start, .chan, .pulses, .capture_input,
		.busy);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		for (int n = 0; n < 4; n++)
			if (capture_irq[n] === 1'b1)
				irq_cnt[n]++;

	task automatic end_sim();
		if (bad_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got,
				exp);
		end
	endtask

	task automatic wr(input logic [8:0] a, input logic [15:0] d,
		input logic w);
		reg_addr <= a;
		reg_wdata <= d;
		reg_word <= w;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [8:0] a, input logic [15:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 cmp({4'h0, reg_rdata}, {4'h0, x});
		@(posedge sys_clk);
	endtask

	// Back-to-back reads, second strobe right after the first
	task automatic rd2(input logic [8:0] a, input logic [8:0] b,
		input logic [15:0] xa, input logic [15:0] xb);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_addr <= b;
		#1 cmp({4'h0, reg_rdata}, {4'h0, xa});
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 cmp({4'h0, reg_rdata}, {4'h0, xb});
		@(posedge sys_clk);
	endtask

	// Configure one channel, send a pulse train, count captures
	task automatic cap(input int ch, input int code, input int f,
		input int np, input int ni);
		logic [8:0] ev;
		ev = ch < 2 ? ADDR_EVDIV_LO : ADDR_EVDIV_HI;
		wr(ADDR_EDGE_CTRL, 16'(code << (2 * ch)), 1'b1);
		wr(ev, 16'(f << (4 * (ch % 2))), 1'b0);
		rd(ev, 16'(8'h88 | (f << (4 * (ch % 2)))));
		wr(ADDR_EDGE_CNT0 + 9'(ch), 16'h0000, 1'b0);
		irq_cnt[ch] = 0;
		chan <= 2'(ch);
		pulses <= 8'(np);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (2) @(posedge sys_clk);
		for (int k = 0; busy !== 1'b0; k++) begin
			if (k > 3000) begin
				bad_count++;
				end_sim();
			end
			@(posedge sys_clk);
		end
		repeat (3) @(posedge sys_clk);
		cmp(20'(irq_cnt[ch]), 20'(ni));
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		foreach (ra[i])
			rd(ra[i], re[i]);
		cmp({2'h0, module_timer_sel}, 20'h00000);
		wr(ADDR_T0_HI, 16'hABCD, 1'b1);
		wr(ADDR_T0_LO, 16'h0057, 1'b0);
		rd(ADDR_T0_HI, 16'hABCD);
		wr(ADDR_T0_LO, 16'h0090, 1'b0);
		rd(ADDR_T0_LO, 16'h005F);
		cmp({16'h0000, timer0_nibble_out}, 20'h00009);
		rd2(ADDR_T0_HI, ADDR_T0_LO, 16'hABCD, 16'h009F);
		wr(ADDR_T0_HI, 16'hFFFF, 1'b1);
		wr(ADDR_T0_LO, 16'h00F0, 1'b0);
		wr(ADDR_T1, 16'hFFFF, 1'b1);
		wr(ADDR_CTRL, 16'h0088, 1'b0);
		timebase_clock <= 1'b1;
		@(posedge sys_clk);
		timebase_clock <= 1'b0;
		#1 cmp({18'h0, timer0_ovf_irq, timer1_ovf_irq}, 20'h3);
		@(posedge sys_clk);
		#1 cmp({18'h0, timer0_ovf_irq, timer1_ovf_irq}, 20'h0);
		@(posedge sys_clk);
		wr(ADDR_CTRL, 16'h0000, 1'b0);
		rd(ADDR_T0_HI, 16'h0000);
		rd(ADDR_T0_LO, 16'h000F);
		rd(ADDR_T1, 16'h0000);
		// Tick phase is unknown, so 2^(k+1) ticks give exactly two counts
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_T1, 16'h0000, 1'b1);
			wr(ADDR_CTRL, 16'(8'h80 | (k << 4)), 1'b0);
			repeat (2 << k) begin
				timebase_clock <= 1'b1;
				@(posedge sys_clk);
				timebase_clock <= 1'b0;
				@(posedge sys_clk);
			end
			wr(ADDR_CTRL, 16'h0000, 1'b0);
			rd(ADDR_T1, 16'h0002);
		end
		wr(ADDR_T0_HI, 16'hABCD, 1'b1);
		wr(ADDR_T0_LO, 16'h0050, 1'b0);
		wr(ADDR_T1, 16'h1234, 1'b1);
		rd(ADDR_T1, 16'h1234);
		#1 ph = time_bus_is_t1;
		repeat (4) begin
			@(posedge sys_clk);
			#1 cmp({19'h0, time_bus_is_t1}, {19'h0, ~ph});
			ph = ~ph;
			cmp({4'h0, shared_time_bus}, ph ? 20'h01234 : 20'h0ABCD);
		end
		@(posedge sys_clk);
		wr(ADDR_SEL, 16'hFFFF, 1'b0);
		rd(ADDR_SEL, 16'h0000);
		wr(ADDR_SEL, 16'h000A, 1'b1);
		wr(ADDR_SEL_EXT, 16'h0003, 1'b0);
		rd(ADDR_SEL_EXT, 16'h00FF);
		cmp({2'h0, module_timer_sel}, 20'h3000A);
		wr(ADDR_SEL_EXT, 16'h0000, 1'b0);
		wr(ADDR_CTRL, 16'h0088, 1'b0);
		rd(ADDR_CTRL, 16'h0088);
		// Pass i uses channel and edge code i mod 4 and divide field i
		for (int i = 0; i < 8; i++) begin
			c = i % 4;
			r = i > 5 ? 64 : 1 << i;
			e = c > 1 ? 2 : 1;
			cap(c, c, i, 2 * r / e, 2);
			rd(ADDR_CAP_HI0 + CAP_HI_STRIDE * 9'(c),
				c % 2 ? 16'h1234 : 16'hABCD);
			rd(ADDR_CAP_LO0 + 9'(c), 16'h005F);
			rd(ADDR_EDGE_SNAP0 + 9'(c), 16'(8'hC0 | (r % 64)));
			rd(ADDR_EDGE_CNT0 + 9'(c), 16'h00C0);
		end
		wr(ADDR_EDGE_SNAP0, 16'h0015, 1'b0);
		rd(ADDR_EDGE_SNAP0, 16'h00D5);
		wr(ADDR_EDGE_CTRL, 16'h00FF, 1'b0);
		rd(ADDR_EDGE_CTRL, 16'h00C0);
		wr(ADDR_CAP_HI0, 16'h5555, 1'b1);
		rd(ADDR_CAP_HI0, 16'hABCD);
		wr(ADDR_CTRL, 16'h0000, 1'b0);
		cap(0, 0, 0, 1, 0);
		end_sim();
	end
endmodule
`default_nettype wire
